// >>> src/octal_port_pkg.sv
package octal_port_pkg;

  localparam int NUM_CHANNELS = 8;
  localparam int NUM_REGS     = 16;
  localparam int DATA_W       = 8;
  localparam int ADDR_W       = 8;

  // address fields
  localparam int REG_LSB      = 0;
  localparam int REG_W        = 4;
  localparam int CHAN_LSB     = 4;
  localparam int CHAN_W       = 3;
  localparam int GLOBAL_BIT   = 7;

  // per-channel register indices (offsets chosen locally where none printed)
  localparam logic [3:0] IRQ_ENABLE_IDX   = 4'h1;
  localparam logic [3:0] MODEM_CTRL_IDX   = 4'h4;
  localparam logic [3:0] MODEM_STATUS_IDX = 4'h6;
  localparam logic [3:0] FEATURE_CTRL_IDX = 4'h8;
  localparam logic [3:0] ENH_FEATURE_IDX  = 4'h9;
  localparam logic [3:0] TX_DATA_IDX      = 4'h0;

  // field positions
  localparam int FEATURE_CTRL_REG_IR_INVERT_BIT = 4;
  localparam int FEATURE_CTRL_REG_HALF_DUPLEX_BIT = 5;
  localparam int FEATURE_CTRL_REG_IR_MODE_BIT   = 6;
  localparam int EFR_AUTO_OUT_BIT   = 6;
  localparam int EFR_AUTO_IN_BIT    = 7;
  localparam int MCR_DTR_BIT        = 0;
  localparam int MCR_RTS_BIT        = 1;
  localparam int MCR_DSR_SEL_BIT    = 2;
  localparam int IER_MODEM_BIT      = 3;

  // global register indices
  localparam logic [3:0] GLOBAL_IRQ_IDX   = 4'h0;
  localparam logic [3:0] GLOBAL_CTRL_IDX  = 4'h1;

  localparam logic [7:0] REG_RESET        = 8'h00;
  localparam int SYNC_STAGES              = 2;

  typedef logic [DATA_W-1:0] byte_t;
  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cycle_e;

endpackage : octal_port_pkg

// >>> src/pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int          WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,   // system clock
  input  wire logic             rst_n, // async reset
  input  wire logic [WIDTH-1:0] din,   // asynchronous inputs
  output logic      [WIDTH-1:0] dout   // synchronised
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= INIT;
      sync_reg <= INIT;
    end
    else
    begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;
endmodule // pin_sync
`default_nettype wire

// >>> src/ir_pulse_codec.sv
`timescale 1ns/1ns
`default_nettype none
module ir_pulse_codec (
  input  wire logic clk,        // system clock
  input  wire logic rst_n,      // async reset
  input  wire logic ir_mode,    // infrared mode selected
  input  wire logic ir_invert,  // invert received pulses
  input  wire logic tx_bit,     // raw transmit bit, idle high
  input  wire logic rx_pin,     // synchronised receive pin
  output logic      tx_pin,     // transmit pin value
  output logic      rx_bit      // decoded receive bit, idle high
);
  logic tx_pin_reg;
  logic tx_pin_next;
  logic rx_bit_reg;
  logic rx_bit_next;
  logic rx_pulse;

  // ir pulses arrive active high; the invert bit handles active-low transceivers
  assign rx_pulse = ir_invert ? ~rx_pin : rx_pin;

  always_comb
  begin
    // normal mode passes data straight; ir sends a pulse for each zero
    tx_pin_next = ir_mode ? ~tx_bit : tx_bit;
    rx_bit_next = ir_mode ? ~rx_pulse : rx_pin;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_pin_reg <= 1'b1;
      rx_bit_reg <= 1'b1;
    end
    else
    begin
      tx_pin_reg <= tx_pin_next;
      rx_bit_reg <= rx_bit_next;
    end
  end

  assign tx_pin = tx_pin_reg;
  assign rx_bit = rx_bit_reg;
endmodule // ir_pulse_codec
`default_nettype wire

// >>> src/octal_serial_host_bus_port.sv
// What this block does
// - address bits 3..0 pick one of sixteen channel registers
// - address bits 6..4 pick one of eight channels
// - address bit 7 set routes access to global registers
// - eight-bit data bus, device drives only during reads
// - bus-style pin high: separate strobes, read strobe active low
// - read strobe falling edge reads register and drives the bus
// - write strobe falls to start, rises to latch the byte
// - single-strobe mode: write strobe pin is read/write level
// - separate-strobe mode: chip select must be low to respond
// - single-strobe mode: chip select is the access strobe
// - one shared open-drain active-low interrupt output
// - receive input idles high in normal mode
// - feature control bit 4 inverts received infrared pulses
// - transmit pin carries normal or infrared-encoded data
// - request-to-send: general, auto flow (enh bit 6), half duplex (bit 5)
// - terminal-ready offers the same three alternatives
// - clear-to-send readable; enh bit 7 makes it gate transmit
// - set-ready readable or alternative auto flow input under bit 7
// - carrier detect sampled and readable by software
// - ring indicator sampled and readable by software
`timescale 1ns/1ns
`default_nettype none
module octal_serial_host_bus_port
  import octal_port_pkg::*;
(
  input  wire logic                                    CLK,                  // 10 MHz clock
  input  wire logic                                    RST_N,                // async reset, active low
  input  wire logic                                    BUS_STYLE,            // 1 separate strobes, 0 single
  input  wire logic [octal_port_pkg::ADDR_W-1:0]       ADDR,                 // register address
  input  wire logic [octal_port_pkg::DATA_W-1:0]       DATA_IN,              // data bus level
  output logic      [octal_port_pkg::DATA_W-1:0]       DATA_OUT,             // read data
  output logic                                         DATA_OE,              // drive data bus
  input  wire logic                                    read_strobe_n,        // read strobe
  input  wire logic                                    write_strobe_n,       // write strobe or r/w level
  input  wire logic                                    CS_N,                 // chip select or strobe
  output logic                                         IRQ_OUT,              // interrupt pin level (always 0)
  output logic                                         IRQ_OE,               // pull interrupt line low
  output logic      [octal_port_pkg::NUM_CHANNELS-1:0] serial_out,           // transmit pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] serial_in,            // receive pins
  output logic      [octal_port_pkg::NUM_CHANNELS-1:0] request_to_send_n,    // rts pins
  output logic      [octal_port_pkg::NUM_CHANNELS-1:0] terminal_ready_n,     // dtr pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] clear_to_send_n,      // cts pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] set_ready_n,          // dsr pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] carrier_detect_n,     // cd pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] ring_indicator_n,     // ri pins
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] TX_BIT,               // core transmit bits
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] TX_ACTIVE,            // core is sending
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] RX_READY,             // core can accept data
  input  wire logic [octal_port_pkg::NUM_CHANNELS-1:0] CHAN_EVENT,           // core interrupt sources
  output logic      [octal_port_pkg::NUM_CHANNELS-1:0] RX_BIT,               // decoded receive bits
  output logic      [octal_port_pkg::NUM_CHANNELS-1:0] TX_ALLOWED            // flow control permits sending
);
  import octal_port_pkg::*;

  localparam int NB = 4 + ADDR_W + DATA_W;
  localparam int CH = NUM_CHANNELS;

  // synchronised pins
  logic [NB-1:0]  bus_sync;
  logic [CH-1:0]  rx_sync;
  logic [CH-1:0]  cts_sync;
  logic [CH-1:0]  dsr_sync;
  logic [CH-1:0]  cd_sync;
  logic [CH-1:0]  ri_sync;

  // address and data share the strobes' synchroniser so all of them arrive on the same edge
  pin_sync #(.WIDTH(NB), .INIT('1)) u_bus_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   ({BUS_STYLE, read_strobe_n, write_strobe_n, CS_N, ADDR, DATA_IN}),
    .dout  (bus_sync)
  );

  pin_sync #(.WIDTH(5*CH), .INIT('1)) u_modem_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .din   ({serial_in, clear_to_send_n, set_ready_n, carrier_detect_n, ring_indicator_n}),
    .dout  ({rx_sync, cts_sync, dsr_sync, cd_sync, ri_sync})
  );

  logic              style_sep;
  logic              rd_n_s;
  logic              wr_n_s;
  logic              cs_n_s;
  logic [ADDR_W-1:0] addr_s;
  byte_t             data_s;
  assign {style_sep, rd_n_s, wr_n_s, cs_n_s, addr_s, data_s} = bus_sync;

  // register storage
  byte_t ier_reg  [CH];
  byte_t mcr_reg  [CH];
  byte_t feature_ctrl_reg_reg [CH];
  byte_t efr_reg  [CH];
  byte_t gctl_reg;
  byte_t ier_next  [CH];
  byte_t mcr_next  [CH];
  byte_t feature_ctrl_reg_next [CH];
  byte_t efr_next  [CH];
  byte_t gctl_next;

  // bus cycle state
  cycle_e             cyc_reg;
  cycle_e             cyc_next;
  logic [ADDR_W-1:0]  addr_reg;
  logic [ADDR_W-1:0]  addr_next;
  byte_t              rdata_reg;
  byte_t              rdata_next;
  logic               oe_reg;
  logic               oe_next;
  logic [CH-1:0]      rts_reg;
  logic [CH-1:0]      rts_next;
  logic [CH-1:0]      dtr_reg;
  logic [CH-1:0]      dtr_next;
  logic [CH-1:0]      allow_reg;
  logic [CH-1:0]      allow_next;
  logic               irq_reg;
  logic               irq_next;

  logic          rd_req;
  logic          wr_req;
  logic          wr_done;
  logic [CH-1:0] pending;
  logic [CH-1:0] ir_mode;
  logic [CH-1:0] ir_inv;

  function automatic logic [CHAN_W-1:0] chan_of(input logic [ADDR_W-1:0] a);
    chan_of = a[CHAN_LSB +: CHAN_W];
  endfunction

  function automatic logic [REG_W-1:0] reg_of(input logic [ADDR_W-1:0] a);
    reg_of = a[REG_LSB +: REG_W];
  endfunction

  function automatic byte_t modem_status(input int c);
    modem_status = {~cd_sync[c], ~ri_sync[c], ~dsr_sync[c], ~cts_sync[c], 4'h0};
  endfunction

  // interrupt pending when a channel event is enabled; modem changes counted via event input
  always_comb
  begin
    for (int c = 0; c < CH; c++)
    begin
      pending[c] = CHAN_EVENT[c] & ier_reg[c][IER_MODEM_BIT];
      ir_mode[c] = feature_ctrl_reg_reg[c][FEATURE_CTRL_REG_IR_MODE_BIT];
      ir_inv[c]  = feature_ctrl_reg_reg[c][FEATURE_CTRL_REG_IR_INVERT_BIT];
    end
  end

  // strobe decoding; the style pin is sampled live, so changing it mid-cycle garbles that cycle
  always_comb
  begin
    if (style_sep)
    begin
      rd_req = !cs_n_s && !rd_n_s;
      wr_req = !cs_n_s && !wr_n_s;
    end
    else
    begin
      rd_req = !cs_n_s && wr_n_s;
      wr_req = !cs_n_s && !wr_n_s;
    end
  end

  function automatic byte_t read_mux(input logic [ADDR_W-1:0] a);
    int c;
    c = int'(chan_of(a));
    read_mux = REG_RESET;
    if (a[GLOBAL_BIT])
    begin
      case (reg_of(a))
        GLOBAL_IRQ_IDX:  read_mux = pending;
        GLOBAL_CTRL_IDX: read_mux = gctl_reg;
        default:         read_mux = REG_RESET;
      endcase
    end
    else
    begin
      case (reg_of(a))
        IRQ_ENABLE_IDX:   read_mux = ier_reg[c];
        MODEM_CTRL_IDX:   read_mux = mcr_reg[c];
        MODEM_STATUS_IDX: read_mux = modem_status(c);
        FEATURE_CTRL_IDX: read_mux = feature_ctrl_reg_reg[c];
        ENH_FEATURE_IDX:  read_mux = efr_reg[c];
        default:          read_mux = REG_RESET;
      endcase
    end
  endfunction

  // bus cycle: the read is taken at the strobe's leading edge, the write at its trailing edge
  always_comb
  begin
    cyc_next   = cyc_reg;
    addr_next  = addr_reg;
    rdata_next = rdata_reg;
    oe_next    = oe_reg;
    wr_done    = 1'b0;
    case (cyc_reg)
      CYC_IDLE:
      begin
        if (rd_req)
        begin
          cyc_next   = CYC_READ;
          addr_next  = addr_s;
          rdata_next = read_mux(addr_s);
          oe_next    = 1'b1;
        end
        else if (wr_req)
        begin
          cyc_next  = CYC_WRITE;
          addr_next = addr_s;
        end
      end
      CYC_READ:
      begin
        if (!rd_req)
        begin
          cyc_next = CYC_IDLE;
          oe_next  = 1'b0;
        end
      end
      CYC_WRITE:
      begin
        // a late data byte is fine: it is recaptured every cycle until the strobe ends
        rdata_next = data_s;
        if (!wr_req)
        begin
          cyc_next = CYC_IDLE;
          wr_done  = 1'b1;
        end
      end
      default:
      begin
        cyc_next = CYC_IDLE;
        oe_next  = 1'b0;
      end
    endcase
  end

  // register writes use the byte sampled in the last cycle of the strobe
  always_comb
  begin
    gctl_next = gctl_reg;
    for (int c = 0; c < CH; c++)
    begin
      ier_next[c]  = ier_reg[c];
      mcr_next[c]  = mcr_reg[c];
      feature_ctrl_reg_next[c] = feature_ctrl_reg_reg[c];
      efr_next[c]  = efr_reg[c];
    end
    if (wr_done)
    begin
      if (addr_reg[GLOBAL_BIT])
      begin
        if (reg_of(addr_reg) == GLOBAL_CTRL_IDX)
          gctl_next = rdata_reg;
      end
      else
      begin
        case (reg_of(addr_reg))
          IRQ_ENABLE_IDX:   ier_next[chan_of(addr_reg)]  = rdata_reg;
          MODEM_CTRL_IDX:   mcr_next[chan_of(addr_reg)]  = rdata_reg;
          FEATURE_CTRL_IDX: feature_ctrl_reg_next[chan_of(addr_reg)] = rdata_reg;
          ENH_FEATURE_IDX:  efr_next[chan_of(addr_reg)]  = rdata_reg;
          default:          gctl_next = gctl_reg;
        endcase
      end
    end
  end

  // modem outputs: half duplex beats auto flow, auto flow beats general output
  always_comb
  begin
    for (int c = 0; c < CH; c++)
    begin
      logic flow_in_ok;
      flow_in_ok = mcr_reg[c][MCR_DSR_SEL_BIT] ? !dsr_sync[c] : !cts_sync[c];
      if (feature_ctrl_reg_reg[c][FEATURE_CTRL_REG_HALF_DUPLEX_BIT])
      begin
        rts_next[c] = !TX_ACTIVE[c];
        dtr_next[c] = !TX_ACTIVE[c];
      end
      else if (efr_reg[c][EFR_AUTO_OUT_BIT])
      begin
        rts_next[c] = !(RX_READY[c] && mcr_reg[c][MCR_RTS_BIT]);
        dtr_next[c] = !(RX_READY[c] && mcr_reg[c][MCR_DTR_BIT]);
      end
      else
      begin
        rts_next[c] = !mcr_reg[c][MCR_RTS_BIT];
        dtr_next[c] = !mcr_reg[c][MCR_DTR_BIT];
      end
      allow_next[c] = !efr_reg[c][EFR_AUTO_IN_BIT] || flow_in_ok;
    end
    irq_next = |pending;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cyc_reg   <= CYC_IDLE;
      addr_reg  <= '0;
      rdata_reg <= REG_RESET;
      oe_reg    <= 1'b0;
      gctl_reg  <= REG_RESET;
      rts_reg   <= '1;
      dtr_reg   <= '1;
      allow_reg <= '1;
      irq_reg   <= 1'b0;
      for (int c = 0; c < CH; c++)
      begin
        ier_reg[c]  <= REG_RESET;
        mcr_reg[c]  <= REG_RESET;
        feature_ctrl_reg_reg[c] <= REG_RESET;
        efr_reg[c]  <= REG_RESET;
      end
    end
    else
    begin
      cyc_reg   <= cyc_next;
      addr_reg  <= addr_next;
      rdata_reg <= rdata_next;
      oe_reg    <= oe_next;
      gctl_reg  <= gctl_next;
      rts_reg   <= rts_next;
      dtr_reg   <= dtr_next;
      allow_reg <= allow_next;
      irq_reg   <= irq_next;
      for (int c = 0; c < CH; c++)
      begin
        ier_reg[c]  <= ier_next[c];
        mcr_reg[c]  <= mcr_next[c];
        feature_ctrl_reg_reg[c] <= feature_ctrl_reg_next[c];
        efr_reg[c]  <= efr_next[c];
      end
    end
  end

  for (genvar g = 0; g < CH; g++)
  begin : g_chan
    ir_pulse_codec u_codec (
      .clk       (CLK),
      .rst_n     (RST_N),
      .ir_mode   (ir_mode[g]),
      .ir_invert (ir_inv[g]),
      .tx_bit    (TX_BIT[g]),
      .rx_pin    (rx_sync[g]),
      .tx_pin    (serial_out[g]),
      .rx_bit    (RX_BIT[g])
    );
  end

  // read data stands only while the device owns the bus
  assign DATA_OUT          = oe_reg ? rdata_reg : REG_RESET;
  assign DATA_OE           = oe_reg;
  assign IRQ_OUT           = 1'b0;
  assign IRQ_OE            = irq_reg;
  assign request_to_send_n = rts_reg;
  assign terminal_ready_n  = dtr_reg;
  assign TX_ALLOWED        = allow_reg;

endmodule // octal_serial_host_bus_port
`default_nettype wire

// >>> verif/octal_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module octal_port_monitor
  import octal_port_pkg::*;
(
  input wire logic                  CLK,             // clock
  input wire logic                  RST_N,           // async reset
  input wire logic                  BUS_STYLE,       // strobe style
  input wire octal_port_pkg::byte_t DATA_OUT,        // read data
  input wire logic                  DATA_OE,         // data drive
  input wire logic                  read_strobe_n,   // read strobe
  input wire logic                  write_strobe_n,  // write strobe or level
  input wire logic                  CS_N,            // chip select
  input wire logic                  IRQ_OUT,         // interrupt level
  input wire logic                  IRQ_OE,          // interrupt pull
  input wire octal_port_pkg::byte_t CHAN_EVENT,      // core events
  input wire octal_port_pkg::byte_t clear_to_send_n, // cts pins
  input wire octal_port_pkg::byte_t set_ready_n,     // dsr pins
  input wire octal_port_pkg::byte_t TX_ALLOWED       // flow permit
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  chk_oe_sep_read: assert property (BUS_STYLE && $rose(DATA_OE) |-> !$past(CS_N, 2) && !$past(read_strobe_n, 2))
    else $error("bus driven without a selected read strobe");
  chk_oe_single_read: assert property (!BUS_STYLE && $rose(DATA_OE) |-> !$past(CS_N, 2) && $past(write_strobe_n, 2))
    else $error("bus driven without a single-strobe read");
  chk_oe_release: assert property ($rose(CS_N) |-> ##[1:5] !DATA_OE)
    else $error("bus not released after access");
  chk_write_quiet: assert property ((!CS_N && !write_strobe_n && read_strobe_n) [*4] |-> !DATA_OE)
    else $error("bus driven during a write");
  chk_ghost_cs: assert property ((BUS_STYLE && CS_N) [*5] |-> !DATA_OE)
    else $error("bus driven while deselected");
  chk_idle_zero: assert property (!DATA_OE |-> DATA_OUT == 8'h00)
    else $error("read data not cleared while idle");
  chk_irq_drain: assert property (IRQ_OUT == 1'b0)
    else $error("interrupt pin driven high");
  chk_irq_release: assert property (CHAN_EVENT == 8'h00 |=> !IRQ_OE)
    else $error("interrupt held without events");
  chk_irq_cause: assert property ($rose(IRQ_OE) |-> $past(CHAN_EVENT) != 8'h00)
    else $error("interrupt raised without an event");
  chk_flow_permit: assert property ((clear_to_send_n == 8'h00 && set_ready_n == 8'h00) [*5] |-> TX_ALLOWED == 8'hff)
    else $error("sending blocked with both inputs asserted");
endmodule // octal_port_monitor
bind octal_serial_host_bus_port octal_port_monitor u_octal_port_monitor (.CLK(CLK), .RST_N(RST_N),
  .BUS_STYLE(BUS_STYLE), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .CS_N(CS_N), .IRQ_OUT(IRQ_OUT), .IRQ_OE(IRQ_OE), .CHAN_EVENT(CHAN_EVENT),
  .clear_to_send_n(clear_to_send_n), .set_ready_n(set_ready_n), .TX_ALLOWED(TX_ALLOWED));
`default_nettype wire

// >>> verif/host_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module host_bus_model
  import octal_port_pkg::*;
(
  input  wire logic                  CLK,            // clock
  input  wire logic                  BUS_STYLE,      // strobe style
  output var  octal_port_pkg::byte_t ADDR,           // address
  output wire octal_port_pkg::byte_t DATA_IN,        // resolved bus level
  input  wire octal_port_pkg::byte_t DATA_OUT,       // device data
  input  wire logic                  DATA_OE,        // device drives
  output var  logic                  read_strobe_n,  // read strobe
  output var  logic                  write_strobe_n, // write strobe or level
  output var  logic                  CS_N,           // chip select
  output var  logic                  hang            // answer never came
);
  logic  drv = 1'b0;
  byte_t hdata = 8'h00;
  byte_t last = 8'h00;
  // a released bus must not keep showing the last byte
  assign DATA_IN = DATA_OE ? DATA_OUT : (drv ? hdata : ~last);
  always @(posedge CLK) last <= DATA_IN;
  initial
  begin
    ADDR = 8'h00;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    CS_N = 1'b1;
    hang = 1'b0;
  end
  task automatic xfer(input logic wr, input byte_t a, input byte_t v, input logic sel);
    int n;
    @(posedge CLK);
    #1;
    ADDR = a;
    hdata = v;
    drv = wr;
    write_strobe_n = !wr;
    read_strobe_n = !BUS_STYLE || wr;
    CS_N = !sel;
    for (n = 0; n < 8; n++)
    begin
      @(posedge CLK);
      if ((wr || !sel) ? n == 3 : DATA_OE === 1'b1)
        break;
    end
    hang = hang | (n == 8);
    #1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    CS_N = 1'b1;
    // data held past the trailing edge so the late sample still sees it
    for (n = 0; n < 8; n++)
    begin
      @(posedge CLK);
      if (n >= 3 && DATA_OE !== 1'b1)
        break;
    end
    hang = hang | (n == 8);
    #1;
    drv = 1'b0;
  endtask
endmodule // host_bus_model
`default_nettype wire

// >>> verif/octal_serial_host_bus_port_bench.sv
`timescale 1ns/1ns
`default_nettype none
module octal_serial_host_bus_port_bench;
  import octal_port_pkg::*;
  logic        CLK = 1'b0, RST_N = 1'b0, BUS_STYLE = 1'b1;
  logic        DATA_OE, IRQ_OUT, IRQ_OE, read_strobe_n, write_strobe_n, CS_N, hang, oe_q = 1'b0;
  byte_t       ADDR, DATA_IN, DATA_OUT, serial_out, RX_BIT, TX_ALLOWED, rts_n, dtr_n, en, g, m;
  byte_t       serial_in, cts_n, dsr_n, cd_n, ri_n, TX_BIT, TX_ACTIVE, RX_READY, CHAN_EVENT;
  byte_t       d [8];
  logic [15:0] expq [$];
  logic [15:0] q;
  int          mismatches = 0, checks_done = 0, seed = 32'h7677, c;
  always #50 CLK = ~CLK;
  octal_serial_host_bus_port u_octal_serial_host_bus_port (.CLK, .RST_N, .BUS_STYLE, .ADDR, .DATA_IN,
    .DATA_OUT, .DATA_OE, .read_strobe_n, .write_strobe_n, .CS_N, .IRQ_OUT, .IRQ_OE, .serial_out, .serial_in,
    .request_to_send_n(rts_n), .terminal_ready_n(dtr_n), .clear_to_send_n(cts_n), .set_ready_n(dsr_n),
    .carrier_detect_n(cd_n), .ring_indicator_n(ri_n), .TX_BIT, .TX_ACTIVE, .RX_READY, .CHAN_EVENT, .RX_BIT,
    .TX_ALLOWED);
  host_bus_model u_host_bus_model (.CLK, .BUS_STYLE, .ADDR, .DATA_IN, .DATA_OUT, .DATA_OE, .read_strobe_n,
    .write_strobe_n, .CS_N, .hang);
  task automatic check(input byte_t got, input byte_t exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input byte_t a, input byte_t v);
    u_host_bus_model.xfer(1'b1, a, v, 1'b1);
  endtask
  task automatic rd(input byte_t a, input byte_t v, input byte_t mk);
    expq.push_back({mk, v & mk});
    u_host_bus_model.xfer(1'b0, a, 8'h00, 1'b1);
  endtask
  task automatic do_reset(input logic style);
    RST_N = 1'b0;
    BUS_STYLE = style;
    repeat (20) @(posedge CLK);
    #1 RST_N = 1'b1;
    tick(4);
  endtask
  task automatic irq_step(input byte_t ev, input byte_t e0);
    CHAN_EVENT = ev;
    en[0] = e0[3];
    wr({4'h0, IRQ_ENABLE_IDX}, e0);
    tick(2);
    check({6'h0, IRQ_OUT, IRQ_OE}, {7'h0, |(ev & en)});
    rd({4'h8, GLOBAL_IRQ_IDX}, ev & en, 8'hff);
  endtask
  // f holds ready, active, cts, dsr, then the expected rts/dtr level and the expected permit
  task automatic flow(input logic [3:0] idx, input byte_t v, input logic [5:0] f);
    wr({1'b0, c[2:0], idx}, v);
    RX_READY[c] = f[5];
    TX_ACTIVE[c] = f[4];
    cts_n[c] = f[3];
    dsr_n[c] = f[2];
    tick(5);
    check({6'h0, rts_n[c], dtr_n[c]}, {6'h0, f[1], f[1]});
    check({7'h0, TX_ALLOWED[c]}, {7'h0, f[0]});
  endtask
  task automatic ir(input byte_t v, input byte_t xo, input byte_t xr);
    wr({1'b0, c[2:0], FEATURE_CTRL_IDX}, v);
    TX_BIT = 8'($random(seed));
    serial_in = 8'($random(seed));
    tick(5);
    check(serial_out ^ TX_BIT, xo);
    check(RX_BIT ^ serial_in, xr);
  endtask
  // a read answer is judged against the oldest outstanding note, mid-cycle where it has settled
  always @(negedge CLK)
  begin
    if (DATA_OE === 1'b1 && oe_q !== 1'b1)
    begin
      if (expq.size() == 0)
        check({7'h0, DATA_OE}, 8'h00);
      else
      begin
        q = expq.pop_front();
        check(DATA_OUT & q[15:8], q[7:0]);
      end
    end
    oe_q = DATA_OE;
  end
  always @(posedge hang)
  begin
    mismatches++;
    finish_test();
  end
  initial
  begin
    {serial_in, cd_n, ri_n, TX_BIT} = 32'hffffffff;
    {cts_n, dsr_n, TX_ACTIVE, RX_READY, CHAN_EVENT} = 40'h0;
    do_reset(1'b1);
    check(rts_n, 8'hff);
    check(dtr_n, 8'hff);
    check(serial_out, 8'hff);
    check(RX_BIT, 8'hff);
    check({5'h0, IRQ_OUT, IRQ_OE, DATA_OE}, 8'h00);
    check(TX_ALLOWED, 8'hff);
    $display("test reset done");
    for (c = 0; c < 8; c++)
    begin
      d[c] = 8'($random(seed));
      en[c] = d[c][3];
      wr({1'b0, c[2:0], IRQ_ENABLE_IDX}, d[c]);
    end
    g = 8'($random(seed));
    wr({4'h8, GLOBAL_CTRL_IDX}, g);
    u_host_bus_model.xfer(1'b1, {4'h2, IRQ_ENABLE_IDX}, ~d[2], 1'b0);
    u_host_bus_model.xfer(1'b0, {4'h3, IRQ_ENABLE_IDX}, 8'h00, 1'b0);
    for (c = 0; c < 8; c++)
      rd({1'b0, c[2:0], IRQ_ENABLE_IDX}, d[c], 8'hff);
    rd({4'h8, GLOBAL_CTRL_IDX}, g, 8'hff);
    rd({4'h0, MODEM_CTRL_IDX}, 8'h00, 8'hff);
    rd(8'h0f, 8'h00, 8'hff);
    $display("test decode done");
    for (c = 0; c < 8; c++)
    begin
      {cd_n, ri_n, dsr_n, cts_n} = $random(seed);
      tick(5);
      rd({1'b0, c[2:0], MODEM_STATUS_IDX}, {~cd_n[c], ~ri_n[c], ~dsr_n[c], ~cts_n[c], 4'h0}, 8'hf0);
    end
    $display("test modem status done");
    irq_step(8'($random(seed)), d[0]);
    irq_step(~en, d[0]);
    irq_step(8'h01, 8'h08);
    irq_step(8'h01, 8'h00);
    $display("test interrupt done");
    c = {$random(seed)} % 8;
    flow(MODEM_CTRL_IDX, 8'h03, 6'b001101);
    flow(ENH_FEATURE_IDX, 8'h40, 6'b001111);
    flow(ENH_FEATURE_IDX, 8'h40, 6'b101101);
    flow(FEATURE_CTRL_IDX, 8'h20, 6'b111101);
    flow(FEATURE_CTRL_IDX, 8'h20, 6'b101111);
    flow(ENH_FEATURE_IDX, 8'hc0, 6'b101110);
    flow(MODEM_CTRL_IDX, 8'h07, 6'b101011);
    flow(MODEM_CTRL_IDX, 8'h07, 6'b100110);
    {cts_n, dsr_n} = 16'h0;
    $display("test flow control done");
    m = 8'h01 << c;
    ir(8'h40, m, m);
    ir(8'h50, m, 8'h00);
    ir(8'h00, 8'h00, 8'h00);
    $display("test infrared done");
    do_reset(1'b0);
    g = 8'($random(seed));
    wr({4'h5, IRQ_ENABLE_IDX}, g);
    rd({4'h5, IRQ_ENABLE_IDX}, g, 8'hff);
    rd({4'h4, IRQ_ENABLE_IDX}, 8'h00, 8'hff);
    tick(2);
    $display("test single strobe done");
    check(8'(expq.size()), 8'h00);
    finish_test();
  end
endmodule // octal_serial_host_bus_port_bench
`default_nettype wire
